// file: bench/ccg_core_props.sv
/* port checker for ccg_core.
 assumes a bind from the bench top. */
`timescale 1ns/1ps
module ccg_core_props
#(
	parameter int FR_HALF = 2
)
(
	input wire logic       mclk_i,
	input wire logic       rst_n_i,
	input wire logic       clock_input_pin_i,
	input wire logic [2:0] clock_mode_straps_i,
	input wire logic       osc_watchdog_disable_i,
	input wire logic       core_clk_o,
	input wire logic       half_cycle_time_o,
	input wire logic       clock_fail_irq_o,
	input wire logic       clock_failed_o,
	input wire logic       multiplier_on_o,
	input wire logic [2:0] clock_mode_o
);
	// ********
	// checks
	// ********
	int   cyc;
	int   quiet;
	logic pin_q;
	logic dir;
	logic pre;
	logic ok;
	assign dir = clock_mode_o == ccg_pkg::MODE_DIRECT;
	assign pre = clock_mode_o == ccg_pkg::MODE_PRESC;
	// skip start-up and the failover cycles
	assign ok = cyc > 8 && !clock_failed_o && !clock_fail_irq_o;
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cyc   <= 0;
			quiet <= 0;
			pin_q <= 1'b0;
		end
		else
		begin
			cyc   <= (cyc < 99) ? cyc + 1 : cyc;
			quiet <= (clock_input_pin_i != pin_q) ? 0 : quiet + 1;
			pin_q <= clock_input_pin_i;
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	AST_MODE: assert property (cyc > 3 |-> $stable(clock_mode_o))
		else $error("mode moved");
	AST_HCT: assert property (half_cycle_time_o == $changed(core_clk_o))
		else $error("no half pulse");
	AST_DIR: assert property (ok && dir |-> core_clk_o == $past(clock_input_pin_i, 3))
		else $error("direct bad");
	AST_PRE: assert property (ok && pre |-> $changed(core_clk_o) ==
		($past(clock_input_pin_i, 4) && !$past(clock_input_pin_i, 5)))
		else $error("prescaler bad");
	AST_OFF: assert property (cyc > 4 && (dir || pre) && osc_watchdog_disable_i
		&& !clock_failed_o |-> !multiplier_on_o)
		else $error("multiplier on");
	AST_IRQM: assert property (clock_fail_irq_o |-> (dir || pre) && !osc_watchdog_disable_i)
		else $error("irq in wrong mode");
	AST_IRQP: assert property (clock_fail_irq_o |=> !clock_fail_irq_o && clock_failed_o)
		else $error("irq pulse bad");
	AST_STICK: assert property (clock_failed_o |=> clock_failed_o)
		else $error("failed dropped");
	AST_WDG: assert property ((dir || pre) && !osc_watchdog_disable_i
		&& quiet == 32 * FR_HALF + 16 |-> clock_failed_o)
		else $error("no failover");
	cover property (clock_fail_irq_o);
	cover property (dir && half_cycle_time_o);
	cover property (pre && half_cycle_time_o);
endmodule

// file: bench/ccg_tb_top.sv
/* bench top: every strap code with the watchdog on and off.
 assumes checker and source model compiled first. */
`timescale 1ns/1ps
module cpu_clock_gen_with_osc_watchdog_tb_top;
	localparam int FRH = 2;
	logic       mclk_i  = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [2:0] straps  = 3'h7;
	logic       dis     = 1'b0;
	logic       run     = 1'b0;
	logic [7:0] half    = 8'h20;
	logic       pin;
	logic       cclk;
	logic       fail;
	logic       mon;
	logic [2:0] mode;
	logic       hct;
	logic       irq;
	int         mismatches = 0;
	int         num_checks = 0;
	int         irqs       = 0;
	int         exp_irqs   = 0;
	int         tmo        = 0;
	always #4 mclk_i = ~mclk_i;
	ccg_xtal_model xtal (.mclk_i(mclk_i), .run_i(run), .half_i(half), .pin_o(pin));
	ccg_core #(.FR_HALF(FRH)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.clock_input_pin_i(pin), .clock_mode_straps_i(straps),
		.osc_watchdog_disable_i(dis), .core_clk_o(cclk), .half_cycle_time_o(hct),
		.clock_fail_irq_o(irq), .clock_failed_o(fail), .multiplier_on_o(mon),
		.clock_mode_o(mode));
	// ********
	// tasks
	// ********
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic near(input logic [31:0] got, input logic [31:0] exp, input int tol);
		num_checks++;
		if (got !== exp && (tol == 0 || $isunknown(got) || got + tol < exp || got > exp + tol))
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// core rising edges expected over n input periods
	function automatic int want(input logic [2:0] m, input int n);
		case (m)
			3'h7: return n * 4;
			3'h6: return n * 3;
			3'h5: return n * 2;
			3'h4: return n * 5;
			3'h3: return n;
			3'h2: return n * 3 / 2;
			3'h1: return n / 2;
			default: return n * 5 / 2;
		endcase
	endfunction
	task automatic rises(input int n, output int r);
		logic p;
		int   t;
		int   h;
		r = 0;
		t = 0;
		h = 0;
		#1;
		p = cclk;
		repeat (n)
		begin
			@(posedge mclk_i);
			#1;
			r += (cclk && !p) ? 1 : 0;
			t += (cclk !== p) ? 1 : 0;
			h += (hct === 1'b1) ? 1 : 0;
			p = cclk;
		end
		near(h, t, 0);
	endtask
	task automatic session(input logic [2:0] c, input logic d);
		int   r;
		logic w;
		w = (c == 3'h3 || c == 3'h1);
		rst_n_i <= 1'b0;
		straps  <= c;
		dis     <= d;
		run     <= 1'b1;
		half    <= 8'h18 + 8'($urandom % 24);
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		straps <= 3'($urandom);
		// the period estimate starts at full scale and needs about 17 input periods
		repeat (40 * half) @(posedge mclk_i);
		#1;
		near(mode, c, 0);
		near(mon, !(w && d), 0);
		rises(16 * half, r);
		near(r, want(c, 8), 1);
		@(posedge mclk_i);
		run <= 1'b0;
		repeat (200) @(posedge mclk_i);
		#1;
		near(fail, w && !d, 0);
		exp_irqs += (w && !d) ? 1 : 0;
		near(irqs, exp_irqs, 0);
		if (w && !d)
		begin
			rises(64, r);
			near(r, 32 / FRH, 1);
			@(posedge mclk_i);
			run <= 1'b1;
			rises(200, r);
			near(fail, 1, 0);
			near(r, 100 / FRH, 1);
		end
	endtask
	initial
	begin
		void'($urandom(32'hf11075bb));
		for (int i = 0; i < 16; i++)
		begin
			session(3'(i >> 1), i[0]);
			@(posedge mclk_i);
		end
		give_verdict();
	end
	always @(posedge mclk_i)
	begin
		tmo  <= tmo + 1;
		irqs <= irqs + ((irq === 1'b1) ? 1 : 0);
		if (tmo == 60000)
		begin
			mismatches++;
			give_verdict();
		end
	end
endmodule
bind ccg_core ccg_core_props #(.FR_HALF(FR_HALF)) props (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .clock_input_pin_i(clock_input_pin_i),
	.clock_mode_straps_i(clock_mode_straps_i), .osc_watchdog_disable_i(osc_watchdog_disable_i),
	.core_clk_o(core_clk_o), .half_cycle_time_o(half_cycle_time_o),
	.clock_fail_irq_o(clock_fail_irq_o), .clock_failed_o(clock_failed_o),
	.multiplier_on_o(multiplier_on_o), .clock_mode_o(clock_mode_o));

// file: bench/ccg_xtal_model.sv
/* input clock source; holds its level while run_i is low.
 assumes half_i of at least 2. */
`timescale 1ns/1ps
module ccg_xtal_model
(
	input  wire logic       mclk_i,
	input  wire logic       run_i,
	input  wire logic [7:0] half_i,
	output logic            pin_o
);
	logic [7:0] cnt = 8'h00;
	logic       lvl = 1'b0;
	assign pin_o = lvl;
	// a dead crystal freezes, it does not float
	always @(posedge mclk_i)
	begin
		if (run_i)
		begin
			cnt <= (cnt >= half_i - 8'h01) ? 8'h00 : cnt + 8'h01;
			lvl <= (cnt >= half_i - 8'h01) ? ~lvl : lvl;
		end
	end
endmodule

// file: verilog/ccg_core.sv
/*
 * core clock generator: direct drive, divide-by-two prescaler or factor
 * multiplier, chosen by straps at reset, with an oscillator watchdog in the direct drive and prescaler modes.
 * assumes the input clock pin and straps are asynchronous and much slower
 * than mclk_i; the core clock is produced as a register output.
 */
`timescale 1ns/1ps
module ccg_core
#(
	parameter int FR_HALF  = ccg_pkg::FR_HALF_DEF,
	parameter int PERIOD_W = ccg_pkg::PERIOD_W_DEF
)
(
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       clock_input_pin_i,
	input  wire logic [2:0] clock_mode_straps_i,
	input  wire logic       osc_watchdog_disable_i,
	output logic            core_clk_o,
	output logic            half_cycle_time_o,
	output logic            clock_fail_irq_o,
	output logic            clock_failed_o,
	output logic            multiplier_on_o,
	output logic [2:0]      clock_mode_o
);
	localparam int FR_W = $clog2(FR_HALF + 1);

	ccg_owd_if owd_bus ();

	logic [2:0]          strap_s1;
	logic [2:0]          strap_s2;
	logic                captured;
	logic [2:0]          mode;
	logic                in_s1;
	logic                in_s2;
	logic                in_s3;
	logic                in_rise;
	logic                in_edge;
	logic [FR_W-1:0]     fr_cnt;
	logic                fr_clk;
	logic                fr_tick;
	logic                is_mul;
	logic                owd_active;
	logic                failed;
	logic [PERIOD_W-1:0] meas;
	logic [PERIOD_W-1:0] period;
	logic [PERIOD_W:0]   acc;
	logic [PERIOD_W:0]   next_acc;
	logic [4:0]          sync_cnt;
	logic [3:0]          f2;
	logic                mul_clk;
	logic                presc_clk;
	logic                next_core;

	// ****************************************
	// strap capture
	// ****************************************
	// plain synchroniser with no reset so it tracks the pins during reset
	always_ff @(posedge mclk_i)
	begin
		strap_s1 <= clock_mode_straps_i;
		strap_s2 <= strap_s1;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			captured <= 1'b0;
			mode     <= ccg_pkg::MODE_DEFAULT;
		end
		else if (!captured)
		begin
			captured <= 1'b1;
			mode     <= strap_s2;
		end
	end

	assign is_mul     = (mode != ccg_pkg::MODE_DIRECT) && (mode != ccg_pkg::MODE_PRESC);
	assign owd_active = captured && !is_mul && !osc_watchdog_disable_i;
	assign f2         = ccg_pkg::twice_factor(mode);

	// ****************************************
	// input clock synchroniser
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			in_s1 <= 1'b0;
			in_s2 <= 1'b0;
			in_s3 <= 1'b0;
		end
		else
		begin
			in_s1 <= clock_input_pin_i;
			in_s2 <= in_s1;
			in_s3 <= in_s2;
		end
	end

	assign in_rise = in_s2 && !in_s3;
	assign in_edge = in_s2 ^ in_s3;

	// ****************************************
	// free-running clock
	// ****************************************
	// stands in for the multiplier's unlocked oscillation; stopped when unused
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fr_cnt <= '0;
			fr_clk <= 1'b0;
		end
		else if (!(owd_active || failed))
		begin
			fr_cnt <= '0;
			fr_clk <= 1'b0;
		end
		else if (fr_cnt == FR_W'(FR_HALF - 1))
		begin
			fr_cnt <= '0;
			fr_clk <= !fr_clk;
		end
		else
			fr_cnt <= fr_cnt + 1'b1;
	end

	assign fr_tick = (fr_cnt == FR_W'(FR_HALF - 1)) && !fr_clk;

	assign owd_bus.enable  = owd_active && !failed;
	assign owd_bus.fr_tick = fr_tick;
	assign owd_bus.in_edge = in_edge;

	ccg_owd u_owd
	(
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.bus     (owd_bus)
	);

	// ****************************************
	// watchdog failure latch
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			failed           <= 1'b0;
			clock_fail_irq_o <= 1'b0;
		end
		else
		begin
			clock_fail_irq_o <= owd_bus.overflow && !failed;
			if (owd_bus.overflow)
				failed <= 1'b1;
		end
	end

	// ****************************************
	// prescaler
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			presc_clk <= 1'b0;
		else if (in_rise)
			presc_clk <= !presc_clk;
	end

	// ****************************************
	// multiplier
	// ****************************************
	// the period estimate moves half way to each measurement so the core
	// frequency never jumps; costs a few input periods of settling
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meas   <= '0;
			period <= '1;
		end
		else if (!is_mul)
		begin
			meas   <= '0;
			period <= '1;
		end
		else if (in_rise)
		begin
			meas   <= '0;
			period <= PERIOD_W'(({1'b0, period} + {1'b0, meas} + 1'b1) >> 1);
		end
		else if (meas != '1)
			meas <= meas + 1'b1;
	end

	always_comb
	begin
		next_acc = acc + {{(PERIOD_W - 3){1'b0}}, f2};
		if (next_acc >= {1'b0, period})
			next_acc = next_acc - {1'b0, period};
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			acc      <= '0;
			mul_clk  <= 1'b0;
			sync_cnt <= '0;
		end
		else if (!is_mul)
		begin
			acc      <= '0;
			mul_clk  <= 1'b0;
			sync_cnt <= '0;
		end
		else
		begin
			// 2f half periods of the core clock per input period
			if (acc + {{(PERIOD_W - 3){1'b0}}, f2} >= {1'b0, period})
				mul_clk <= !mul_clk;
			// resync on a rising edge only: there a core toggle lines up for every factor
			if (in_rise && (sync_cnt >= {1'b0, f2} - 5'h1))
			begin
				sync_cnt <= '0;
				acc      <= next_acc >> 1;
			end
			else
			begin
				if (in_edge)
					sync_cnt <= sync_cnt + 1'b1;
				acc <= next_acc;
			end
		end
	end

	// ****************************************
	// core clock select
	// ****************************************
	always_comb
	begin
		if (!captured)
			next_core = 1'b0;
		else if (failed)
			next_core = fr_clk;
		else if (mode == ccg_pkg::MODE_DIRECT)
			next_core = in_s2;
		else if (mode == ccg_pkg::MODE_PRESC)
			next_core = presc_clk;
		else
			next_core = mul_clk;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			core_clk_o        <= 1'b0;
			half_cycle_time_o <= 1'b0;
			clock_failed_o    <= 1'b0;
			multiplier_on_o   <= 1'b0;
			clock_mode_o      <= ccg_pkg::MODE_DEFAULT;
		end
		else
		begin
			core_clk_o        <= next_core;
			half_cycle_time_o <= next_core ^ core_clk_o;
			clock_failed_o    <= failed;
			multiplier_on_o   <= captured && (is_mul || owd_active || failed);
			clock_mode_o      <= mode;
		end
	end

endmodule

// file: verilog/ccg_owd.sv
/*
 * oscillator watchdog counter: counts free-running clock ticks and is
 * cleared by every transition of the input clock.
 * assumes fr_tick and in_edge are one-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
module ccg_owd
(
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	ccg_owd_if.owd    bus
);
	logic [ccg_pkg::OWD_CNT_W-1:0] count;

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			count <= '0;
		else if (!bus.enable || bus.in_edge)
			count <= '0;
		else if (bus.fr_tick && !bus.overflow)
			count <= count + 1'b1;
	end

	// overflow is a level; it stays until the enable drops or an input edge clears the count
	assign bus.overflow = (count == ccg_pkg::OWD_CNT_W'(ccg_pkg::OWD_OVERFLOW));

endmodule

// file: verilog/ccg_owd_if.sv
/*
 * signals between the clock generator and its oscillator watchdog counter.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface ccg_owd_if;
	logic enable;
	logic fr_tick;
	logic in_edge;
	logic overflow;

	modport gen
	(
		output enable,
		output fr_tick,
		output in_edge,
		input  overflow
	);
	modport owd
	(
		input  enable,
		input  fr_tick,
		input  in_edge,
		output overflow
	);
endinterface

// file: verilog/ccg_pkg.sv
/*
 * constants shared by the core clock generator and its oscillator watchdog.
 * assumes a single system clock of 125 mhz feeding every flip-flop.
 */
package ccg_pkg;

	// ****************************************
	// clock mode strap codes
	// ****************************************
	localparam logic [2:0] MODE_MUL_4   = 3'h7;
	localparam logic [2:0] MODE_MUL_3   = 3'h6;
	localparam logic [2:0] MODE_MUL_2   = 3'h5;
	localparam logic [2:0] MODE_MUL_5   = 3'h4;
	localparam logic [2:0] MODE_DIRECT  = 3'h3;
	localparam logic [2:0] MODE_MUL_1P5 = 3'h2;
	localparam logic [2:0] MODE_PRESC   = 3'h1;
	localparam logic [2:0] MODE_MUL_2P5 = 3'h0;
	localparam logic [2:0] MODE_DEFAULT = MODE_MUL_4;

	// ****************************************
	// watchdog, free-running clock and multiplier
	// ****************************************
	localparam int         OWD_OVERFLOW  = 16;
	localparam int         OWD_CNT_W     = 5;
	localparam int         FR_HALF_DEF   = 2;
	localparam int         PERIOD_W_DEF  = 16;
	localparam logic [3:0] TWICE_F_W     = 4'h4;

	// twice the multiplication factor, so 1.5 and 2.5 stay integral
	function automatic logic [3:0] twice_factor(input logic [2:0] mode);
		logic [3:0] f2;
		f2 = 4'h8;
		unique case (mode)
			MODE_MUL_4:   f2 = 4'h8;
			MODE_MUL_3:   f2 = 4'h6;
			MODE_MUL_2:   f2 = 4'h4;
			MODE_MUL_5:   f2 = 4'ha;
			MODE_MUL_1P5: f2 = 4'h3;
			MODE_MUL_2P5: f2 = 4'h5;
			default:      f2 = 4'h2;
		endcase
		return f2;
	endfunction

endpackage
